// [hdl/rx_chsel_defines.vh]
// register map, field positions and constants of the receive channel selector
`ifndef RX_CHSEL_DEFINES_VH
`define RX_CHSEL_DEFINES_VH

// register byte offsets (apb, one aligned word each)
`define RCS_OFF_DATA 8'h00
`define RCS_OFF_MCTL 8'h04
`define RCS_OFF_STAT 8'h08
`define RCS_OFF_EN_BASE 4'h1

// multichannel_control field positions
`define RCS_MCTL_MODE_BIT 0
`define RCS_MCTL_BLK_LO 2
`define RCS_MCTL_BLK_HI 4
`define RCS_MCTL_PA_LO 5
`define RCS_MCTL_PA_HI 6
`define RCS_MCTL_PB_LO 7
`define RCS_MCTL_PB_HI 8
`define RCS_MCTL_PMODE_BIT 9

// status field positions
`define RCS_STAT_READY_BIT 0
`define RCS_STAT_OVR_BIT 1

// reset values and sizes
`define RCS_EN_RESET 32'h00000000
`define RCS_NUM_CH 128
`define RCS_LAST_CH 7'h7F
`define RCS_WORD_BITS 16
`define RCS_FIFO_DEPTH 4

`endif

// [hdl/rx_pin_sync.v]
// two flip-flop synchroniser for a group of slow asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module rx_pin_sync #(
  parameter WIDTH = 3
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;

  // first stage feeds only the second stage
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      meta_r <= {WIDTH{1'b0}};
      stable_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule
`default_nettype wire

// [hdl/rx_word_fifo.v]
// small valid/ready word fifo between the deserialiser and the bus
`timescale 1ns/100ps
`default_nettype none

module rx_word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam integer DEPTH_N = DEPTH;
  localparam [AW:0] FULL_CNT = DEPTH_N[AW:0];

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count_r != FULL_CNT);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap naturally; depth must be a power of two
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // storage needs no reset
  always @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule
`default_nettype wire

// [hdl/rx_multichannel_channel_select.v]
// receive deserialiser with multichannel selection and apb registers
// Notes on behaviour
// - current block codes 4 to 7 mean blocks 4 to 7, sixteen channels each.
// - current block is read-only bits 4:2 of control, live; 0-3 blocks 0-3.
// - selection mode 0 accepts all 128 channels, enables ignored.
// - selection mode 1 accepts only channels whose enable bit is set.
// - two-partition mode uses only the first enable register, 32 channels.
// - eight-partition mode uses all four enable registers, 128 channels.
// - partition mode matters only while selection mode is on.
// - two-partition: bits 0-15 partition A block, 16-31 partition B block.
// - partition A block from its field, partition B block from its own.
// - eight-partition: first register covers fixed channels 0 to 31.
// - enable bit 0 disables, 1 enables its channel under selection mode.
// - all enable register bits read/write, zero after reset.
// - register n bit k controls channel 32n+k in 128-channel mode.
// - partition A field picks even blocks, partition B field odd blocks.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "rx_chsel_defines.vh"

module rx_multichannel_channel_select #(
  parameter WORD_BITS = `RCS_WORD_BITS,
  parameter FIFO_DEPTH = `RCS_FIFO_DEPTH,
  parameter FIFO_AW = 2
) (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_clk_pin,
  input wire rx_frame_sync_pin,
  input wire rx_data_pin,
  output wire [2:0] rx_current_block
);

  // word length is a parameter; the bit counter is six bits, but 32-bit prdata limits it to <= 32
  localparam integer LAST_BIT_I = WORD_BITS - 1;
  localparam [5:0] LAST_BIT = LAST_BIT_I[5:0];

  // pins after the synchroniser
  wire [2:0] pins_sync;
  wire rx_clk_s;
  wire rx_fs_s;
  wire rx_data_s;

  // link edge detection and framing state
  reg rx_clk_d_r;
  reg in_frame_r;
  reg [5:0] bit_cnt_r;
  reg [6:0] chan_r;
  reg [WORD_BITS-1:0] shift_r;
  reg word_done_r;
  reg [WORD_BITS-1:0] word_r;
  reg [6:0] word_ch_r;
  wire rx_rise;
  wire [WORD_BITS-1:0] shift_nxt;

  // software-visible control state
  reg rx_channel_select_mode_r;
  reg rx_partition_mode_r;
  reg [1:0] rx_partition_a_block_r;
  reg [1:0] rx_partition_b_block_r;
  reg [127:0] receive_channel_enable_r;
  reg overrun_r;

  // bus decode
  wire setup_done;
  wire access_done;
  wire wr_en;
  wire rd_pop;
  wire en_hit;
  wire [6:0] en_lsb;
  reg [31:0] rdata_nxt;
  reg mapped_nxt;

  // fifo hookup
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WORD_BITS-1:0] fifo_out_data;
  wire word_accept;
  wire overrun_set;

  // decides whether a received channel is kept
  function chan_accept;
    input [6:0] ch;
    input sel_mode;
    input part_mode;
    input [1:0] pa_blk;
    input [1:0] pb_blk;
    input [127:0] en;
    begin
      if (!sel_mode) begin
        chan_accept = 1'b1;
      end else if (part_mode) begin
        chan_accept = en[ch];
      end else if (ch[6:4] == {pa_blk, 1'b0}) begin
        chan_accept = en[{3'b000, ch[3:0]}];
      end else if (ch[6:4] == {pb_blk, 1'b1}) begin
        chan_accept = en[{3'b001, ch[3:0]}];
      end else begin
        chan_accept = 1'b0;
      end
    end
  endfunction

  // true for every offset that answers without an error
  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a[1:0] == 2'b00) &&
                    ((a == `RCS_OFF_DATA) || (a == `RCS_OFF_MCTL) ||
                     (a == `RCS_OFF_STAT) ||
                     (a[7:4] == `RCS_OFF_EN_BASE));
    end
  endfunction

  // link pins cross into the system clock here
  rx_pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({rx_clk_pin, rx_frame_sync_pin, rx_data_pin}),
    .sync_out(pins_sync)
  );

  assign rx_clk_s = pins_sync[2];
  assign rx_fs_s = pins_sync[1];
  assign rx_data_s = pins_sync[0];

  // data and sync are sampled on the link clock rising edge
  assign rx_rise = rx_clk_s & ~rx_clk_d_r;
  assign shift_nxt = {shift_r[WORD_BITS-2:0], rx_data_s};

  // the block indicator is the live channel counter's top bits
  assign rx_current_block = chan_r[6:4];

  // frame sync restarts the channel count; its edge carries bit 0
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_clk_d_r <= 1'b0;
      in_frame_r <= 1'b0;
      bit_cnt_r <= 6'h00;
      chan_r <= 7'h00;
      shift_r <= {WORD_BITS{1'b0}};
      word_done_r <= 1'b0;
      word_r <= {WORD_BITS{1'b0}};
      word_ch_r <= 7'h00;
    end else begin
      rx_clk_d_r <= rx_clk_s;
      word_done_r <= 1'b0;
      // a sync inside a frame restarts it; the partial word is dropped
      if (rx_rise && rx_fs_s) begin
        in_frame_r <= 1'b1;
        bit_cnt_r <= 6'h01;
        chan_r <= 7'h00;
        shift_r <= shift_nxt;
      end else if (rx_rise && in_frame_r) begin
        shift_r <= shift_nxt;
        if (bit_cnt_r == LAST_BIT) begin
          bit_cnt_r <= 6'h00;
          word_done_r <= 1'b1;
          word_r <= shift_nxt;
          word_ch_r <= chan_r;
          // frame closes after the last of the 128 channels
          if (chan_r == `RCS_LAST_CH) begin
            in_frame_r <= 1'b0;
            chan_r <= 7'h00;
          end else begin
            chan_r <= chan_r + 7'h01;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
      end
    end
  end

  // words from disabled channels never reach the fifo
  // enables are read as the word completes, so a change made mid-channel
  // applies from the next completed word on
  assign word_accept = chan_accept(word_ch_r, rx_channel_select_mode_r,
                                   rx_partition_mode_r,
                                   rx_partition_a_block_r,
                                   rx_partition_b_block_r,
                                   receive_channel_enable_r);
  assign fifo_in_valid = word_done_r & word_accept;
  // a full fifo loses the word and flags it, only for kept channels
  assign overrun_set = fifo_in_valid & ~fifo_in_ready;

  rx_word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_word_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(word_r),
    .out_valid(fifo_out_valid),
    .out_ready(rd_pop),
    .out_data(fifo_out_data)
  );

  // apb: one wait state, answer registered at the end of it
  assign setup_done = psel & penable & ~pready;
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & addr_mapped(paddr);
  // the pop shares the edge that captures prdata, so a word that lands
  // during the wait state stays queued instead of being popped unread
  assign rd_pop = setup_done & ~pwrite & (paddr == `RCS_OFF_DATA) &
                  fifo_out_valid;
  assign en_hit = (paddr[7:4] == `RCS_OFF_EN_BASE) && (paddr[1:0] == 2'b00);
  assign en_lsb = {paddr[3:2], 5'b00000};

  // read mux; unmapped offsets read zero and raise pslverr
  // an empty fifo reads zero rather than a stale word
  always @* begin
    rdata_nxt = 32'h00000000;
    mapped_nxt = addr_mapped(paddr);
    if (paddr == `RCS_OFF_DATA) begin
      rdata_nxt[WORD_BITS-1:0] = fifo_out_data;
      if (!fifo_out_valid) begin
        rdata_nxt = 32'h00000000;
      end
    end else if (paddr == `RCS_OFF_MCTL) begin
      rdata_nxt[`RCS_MCTL_MODE_BIT] = rx_channel_select_mode_r;
      rdata_nxt[`RCS_MCTL_BLK_HI:`RCS_MCTL_BLK_LO] = chan_r[6:4];
      rdata_nxt[`RCS_MCTL_PA_HI:`RCS_MCTL_PA_LO] = rx_partition_a_block_r;
      rdata_nxt[`RCS_MCTL_PB_HI:`RCS_MCTL_PB_LO] = rx_partition_b_block_r;
      rdata_nxt[`RCS_MCTL_PMODE_BIT] = rx_partition_mode_r;
    end else if (paddr == `RCS_OFF_STAT) begin
      rdata_nxt[`RCS_STAT_READY_BIT] = fifo_out_valid;
      rdata_nxt[`RCS_STAT_OVR_BIT] = overrun_r;
    end else if (en_hit) begin
      rdata_nxt = receive_channel_enable_r[en_lsb +: 32];
    end
  end

  // bus answer flops; the top's bus outputs prdata, pready and pslverr all come from here
  // writes return zero on prdata; pslverr only pulses with pready
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_done;
      pslverr <= setup_done & ~mapped_nxt;
      if (setup_done) begin
        prdata <= pwrite ? 32'h00000000 : rdata_nxt;
      end
    end
  end

  // control register writes; block indicator bits are read-only
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_channel_select_mode_r <= 1'b0;
      rx_partition_mode_r <= 1'b0;
      rx_partition_a_block_r <= 2'b00;
      rx_partition_b_block_r <= 2'b00;
    end else if (wr_en && (paddr == `RCS_OFF_MCTL)) begin
      rx_channel_select_mode_r <= pwdata[`RCS_MCTL_MODE_BIT];
      rx_partition_mode_r <= pwdata[`RCS_MCTL_PMODE_BIT];
      rx_partition_a_block_r <= pwdata[`RCS_MCTL_PA_HI:`RCS_MCTL_PA_LO];
      rx_partition_b_block_r <= pwdata[`RCS_MCTL_PB_HI:`RCS_MCTL_PB_LO];
    end
  end

  // four enable words packed so bit 32n+k is channel 32n+k
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      receive_channel_enable_r <= {4{`RCS_EN_RESET}};
    end else if (wr_en && en_hit) begin
      receive_channel_enable_r[en_lsb +: 32] <= pwdata;
    end
  end

  // overrun is write-one-to-clear; a new overrun beats the clear
  // sticky until cleared, so a burst of lost words reads as one event
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      overrun_r <= 1'b0;
    end else if (overrun_set) begin
      overrun_r <= 1'b1;
    end else if (wr_en && (paddr == `RCS_OFF_STAT) &&
                 pwdata[`RCS_STAT_OVR_BIT]) begin
      overrun_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [dv/rx_chsel_monitor.sv]
// port checker for the receive channel selector
`timescale 1ns/100ps
`default_nettype none
module rx_chsel_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] rx_current_block
);
  logic hit;
  logic rd_ctl;
  // only these words answer without an error
  assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
  assign rd_ctl = pready && !pwrite && paddr == 8'h04;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  blk_reset_a: assert property (disable iff (1'b0)
    !reset_n |=> rx_current_block == 3'h0) else $error("block not cleared");
  blk_step_a: assert property ($changed(rx_current_block) |->
    rx_current_block == $past(rx_current_block) + 3'h1 ||
    rx_current_block == 3'h0) else $error("block skipped");
  blk_hold_a: assert property ($changed(rx_current_block) &&
    rx_current_block != 3'h0 |=> $stable(rx_current_block) [*8])
    else $error("block moved early");
  rdy_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
  rdy_idle_a: assert property (!(psel && penable) |-> !pready)
    else $error("stray ready");
  err_map_a: assert property (pready |-> pslverr == !hit)
    else $error("wrong error flag");
  err_zero_a: assert property (pready && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  ctl_read_a: assert property (rd_ctl |-> prdata[31:10] == 22'h0 &&
    !prdata[1] && (prdata[4:2] == rx_current_block ||
    prdata[4:2] == $past(rx_current_block))) else $error("bad control");
endmodule
bind rx_multichannel_channel_select rx_chsel_monitor u_mon (.sys_clk,
  .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .rx_current_block);
`default_nettype wire

// [dv/rx_link_source.sv]
// serial frame source standing in for a multichannel codec
`timescale 1ns/100ps
`default_nettype none
module rx_link_source (
  input wire logic go,
  output var logic lclk,
  output var logic fsync,
  output var logic sdata,
  output var logic busy
);
  int c;
  int b;
  logic [15:0] w;
  initial begin
    lclk = 1'b0;
    fsync = 1'b0;
    sdata = 1'b1;
    busy = 1'b0;
  end
  // one frame per go, msb first; clock idles low between frames
  always @(posedge go) begin
    busy = 1'b1;
    for (c = 0; c < 128; c++) begin
      w = {c[6:0], 9'h0A5};
      for (b = 15; b >= 0; b--) begin
        sdata = w[b];
        fsync = (c == 0 && b == 15);
        #40 lclk = 1'b1;
        #40 lclk = 1'b0;
      end
    end
    fsync = 1'b0;
    // released line shows the inverse so a stale bit never looks valid
    sdata = ~sdata;
    #300 busy = 1'b0;
  end
endmodule
`default_nettype wire

// [dv/rx_multichannel_channel_select_tb.sv]
// self-checking bench for the receive channel selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, x); end end
module rx_multichannel_channel_select_tb;
  typedef struct packed {
    logic sel;
    logic pm;
    logic [1:0] pa;
    logic [1:0] pb;
    logic [127:0] en;
  } row_t;
  logic sys_clk, reset_n, psel, penable, pwrite, go, e;
  logic pready, pslverr, lclk, fs, sd, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, st, xq;
  logic [2:0] blk, mx;
  int fail_count, num_checks, i, n, r;
  int exp_q [$];
  row_t rows [3];
  rx_multichannel_channel_select u_dut (.sys_clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_clk_pin(lclk), .rx_frame_sync_pin(fs), .rx_data_pin(sd),
    .rx_current_block(blk));
  rx_link_source u_src (.go, .lclk, .fsync(fs), .sdata(sd), .busy);
  always #5 sys_clk = ~sys_clk;
  // highest block seen in the current frame
  always @(posedge sys_clk) mx <= go ? 3'h0 : (blk > mx ? blk : mx);
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one apb transfer, held until ready; a lost answer ends the run
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic re);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      end_sim();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic bit acc(int c, row_t x);
    if (!x.sel || x.pm) return !x.sel || x.en[c];
    if (c / 16 == 2 * x.pa) return x.en[c % 16];
    return c / 16 == 2 * x.pb + 1 && x.en[16 + c % 16];
  endfunction
  function automatic logic [15:0] word(int c);
    return {c[6:0], 9'h0A5};
  endfunction
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, go} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    // all channels; selection off so enables and partition mode are moot
    rows[0] = '{1'b0, 1'b1, 2'h0, 2'h0, 128'h0};
    // two partitions: blocks 6 and 1, upper enables must be ignored
    rows[1] = '{1'b1, 1'b0, 2'h3, 2'h0, {{96{1'b1}}, 32'h8001_8001}};
    // eight partitions: channels 0, 31, 48, 127
    rows[2] = '{1'b1, 1'b1, 2'h1, 2'h2,
      {32'h8000_0000, 32'h0, 32'h0001_0000, 32'h8000_0001}};
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'(16 + 4 * i), 32'h0, q, e);
      `CHK(q, 32'h0)
      apb(1'b1, 8'(16 + 4 * i), 32'hFFFF_FFFF ^ i, q, e);
      apb(1'b0, 8'(16 + 4 * i), 32'h0, q, e);
      `CHK(q, 32'hFFFF_FFFF ^ i)
    end
    apb(1'b0, 8'h0C, 32'h0, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    apb(1'b1, 8'h04, 32'hFFFF_FFFF, q, e);
    apb(1'b0, 8'h04, 32'h0, q, e);
    `CHK(q, 32'h0000_03E1)
    for (r = 0; r < 3; r++) begin
      apb(1'b1, 8'h04, {22'h0, rows[r].pm, rows[r].pb, rows[r].pa, 4'h0,
        rows[r].sel}, q, e);
      for (i = 0; i < 4; i++)
        apb(1'b1, 8'(16 + 4 * i), rows[r].en[32 * i +: 32], q, e);
      exp_q = {};
      for (i = 0; i < 128; i++)
        if (acc(i, rows[r])) exp_q.push_back(i);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      st = 32'h0;
      n = 0;
      // drain while the frame runs; the far side never waits for us
      while ((busy || st[0]) && n < 20000) begin
        apb(1'b0, 8'h08, 32'h0, st, e);
        if (st[0] === 1'b1) begin
          apb(1'b0, 8'h00, 32'h0, q, e);
          xq = {16'h0, exp_q.size() ? word(exp_q.pop_front()) : 16'h0};
          `CHK(q, xq)
        end
        n++;
      end
      if (n >= 20000) begin
        fail_count++;
        end_sim();
      end
      `CHK(exp_q.size(), 0)
      `CHK(st[1], 1'b0)
      `CHK(mx, 3'h7)
    end
    // nobody drains: four words stay queued and the rest set overrun
    apb(1'b1, 8'h04, 32'h0, q, e);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      fail_count++;
      end_sim();
    end
    apb(1'b0, 8'h08, 32'h0, q, e);
    `CHK(q, 32'h0000_0003)
    apb(1'b1, 8'h08, 32'h0000_0002, q, e);
    apb(1'b0, 8'h08, 32'h0, q, e);
    `CHK(q, 32'h0000_0001)
    apb(1'b0, 8'h00, 32'h0, q, e);
    `CHK(q, {16'h0, word(0)})
    // second reset in mid-run clears enables and control
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    `CHK(q, 32'h0)
    apb(1'b0, 8'h04, 32'h0, q, e);
    `CHK(q, 32'h0)
    apb(1'b0, 8'h08, 32'h0, q, e);
    `CHK(q, 32'h0)
    end_sim();
  end
endmodule
`default_nettype wire
